// file: qdc_control.sv
// Control byte decoder and double-buffered update of four DAC channels
//
// Operation
// R1 - Mode 00, normal data: store word in selected temp hold only.
// R2 - Control bits 2:1 pick channel A, B, C or D.
// R3 - Mode 00 with power-down flag: store code in selected temp hold only.
// R4 - Mode 01: write selected temp hold and load its output code.
// R5 - Mode 10: write selected channel, load all outputs, others from temps.
// R6 - Broadcast with bit 2 clear: all outputs load from their temps.
// R7 - Broadcast with bit 2 set, flag clear: all outputs load received data.
// R8 - Broadcast with bit 2 set, flag set: all outputs take power-down code.
// R9 - First data byte is the upper eight conversion bits.
// R10 - With power-down flag, upper byte bits 7:6 are the power-down code.
// R11 - Second byte bits 7:6 are the two low bits, rest ignored.
// R12 - Update happens on the acknowledge falling edge after second byte.
// R13 - Power-on reset clears registers so unwritten channels read zero.
// R14 - Each channel has a 12-bit temp hold: code on top, data below.
// R15 - Each channel has a 12-bit output code register, same layout.
// R16 - Whole control byte is captured before the data bytes.
// R17 - Without power-down flag, byte pairs repeat until stop or restart.
// R18 - With power-down flag, master sends exactly two data bytes.
// R19 - Master sets bits 7:6 to zero outside broadcast; bit 3 is free.
`include "qdc_map.svh"

module qdc_control
  import qdc_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int WORD_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic frame_begin,
  input wire logic frame_end,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic ack_fall,
  output logic [7:0] control_byte,
  output logic [7:0] upper_data_byte,
  output logic [7:0] lower_data_byte,
  output logic update_done,
  output logic [WORD_W-1:0] temp_hold_ch_a,
  output logic [WORD_W-1:0] temp_hold_ch_b,
  output logic [WORD_W-1:0] temp_hold_ch_c,
  output logic [WORD_W-1:0] temp_hold_ch_d,
  output logic [WORD_W-1:0] output_code_ch_a,
  output logic [WORD_W-1:0] output_code_ch_b,
  output logic [WORD_W-1:0] output_code_ch_c,
  output logic [WORD_W-1:0] output_code_ch_d
);

  qdc_core_t st;
  qdc_core_t next_st;

  logic update_mode_hi;
  logic update_mode_lo;
  logic powerdown_flag;
  logic channel_pick_hi;
  logic channel_pick_lo;
  logic [1:0] mode;
  logic [1:0] pick;
  logic fire;
  logic [WORD_W-1:0] new_word;
  logic [CHANNELS-1:0] wr_temp;
  logic [CHANNELS-1:0] ld_out;
  logic [CHANNELS-1:0] ld_new;
  logic [WORD_W-1:0] channel_temp_hold [CHANNELS];
  logic [WORD_W-1:0] channel_output_code [CHANNELS];

  assign update_mode_hi = st.control[`QDC_CTL_MODE_HI];
  assign update_mode_lo = st.control[`QDC_CTL_MODE_LO];
  assign powerdown_flag = st.control[`QDC_CTL_PD_FLAG];
  assign channel_pick_hi = st.control[`QDC_CTL_PICK_HI];
  assign channel_pick_lo = st.control[`QDC_CTL_PICK_LO];
  assign mode = {update_mode_hi, update_mode_lo};
  assign pick = {channel_pick_hi, channel_pick_lo}; // R2

  // Update fires only on the acknowledge falling edge after the low byte
  assign fire = (st.state == QDC_ST_PEND) && ack_fall; // R12

  // Power-down word carries the code on top and zero data below
  always_comb begin
    if (powerdown_flag) begin
      new_word = {st.upper[`QDC_PD_CODE_HI], st.upper[`QDC_PD_CODE_LO], `QDC_DATA_ZERO}; // R10
    end else begin
      new_word = {2'h0, st.upper, st.lower[`QDC_LOW_BITS_HI:`QDC_LOW_BITS_LO]}; // R9 R11
    end
  end

  // Per-channel strobes; bits 7:6 and 3 of the control byte are not decoded
  always_comb begin
    wr_temp = '0;
    ld_out = '0;
    ld_new = '0;
    if (fire) begin
      unique case (mode)
        `QDC_MODE_TEMP: begin
          wr_temp[pick] = 1'b1; // R1 R3
        end
        `QDC_MODE_SINGLE: begin
          wr_temp[pick] = 1'b1; // R4
          ld_out[pick] = 1'b1;
          ld_new[pick] = 1'b1;
        end
        `QDC_MODE_ALL: begin
          wr_temp[pick] = 1'b1; // R5
          ld_out = '1;
          ld_new[pick] = 1'b1;
        end
        `QDC_MODE_BCAST: begin
          ld_out = '1; // R6
          ld_new = channel_pick_hi ? '1 : '0; // R7 R8
        end
      endcase
    end
  end

  // Byte sequencer
  always_comb begin
    next_st = st;
    next_st.updated = fire;
    if (frame_begin) begin
      next_st.state = QDC_ST_CTRL;
    end else if (frame_end) begin
      next_st.state = QDC_ST_IDLE;
    end else begin
      unique case (st.state)
        QDC_ST_IDLE: begin
          next_st.state = QDC_ST_IDLE;
        end
        QDC_ST_CTRL: begin
          if (rx_valid) begin
            next_st.control = rx_byte; // R16
            next_st.state = QDC_ST_HIGH;
          end
        end
        QDC_ST_HIGH: begin
          if (rx_valid) begin
            next_st.upper = rx_byte; // R9
            next_st.state = QDC_ST_LOW;
          end
        end
        QDC_ST_LOW: begin
          if (rx_valid) begin
            next_st.lower = rx_byte; // R11
            next_st.state = QDC_ST_PEND;
          end
        end
        QDC_ST_PEND: begin
          if (ack_fall) begin
            // A power-down write is exactly one pair; data pairs may repeat
            next_st.state = powerdown_flag ? QDC_ST_DONE : QDC_ST_HIGH; // R17 R18
          end
        end
        QDC_ST_DONE: begin
          next_st.state = QDC_ST_DONE;
        end
        default: begin
          next_st.state = QDC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st.state <= QDC_ST_IDLE;
      st.control <= `QDC_CTL_RESET;
      st.upper <= `QDC_BYTE_RESET;
      st.lower <= `QDC_BYTE_RESET;
      st.updated <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Temp hold and output code pair per channel, both cleared at reset
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    qdc_channel #(
      .WORD_W(WORD_W)
    ) u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_temp(wr_temp[i]),
      .ld_out(ld_out[i]),
      .ld_new(ld_new[i]),
      .new_word(new_word),
      .temp(channel_temp_hold[i]),
      .code(channel_output_code[i])
    ); // R13 R14 R15
  end

  assign control_byte = st.control;
  assign upper_data_byte = st.upper;
  assign lower_data_byte = st.lower;
  assign update_done = st.updated;
  assign temp_hold_ch_a = channel_temp_hold[0];
  assign temp_hold_ch_b = channel_temp_hold[1];
  assign temp_hold_ch_c = channel_temp_hold[2];
  assign temp_hold_ch_d = channel_temp_hold[3];
  assign output_code_ch_a = channel_output_code[0];
  assign output_code_ch_b = channel_output_code[1];
  assign output_code_ch_c = channel_output_code[2];
  assign output_code_ch_d = channel_output_code[3];

  ctrl_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
    (st.state == QDC_ST_CTRL && rx_valid && !frame_begin && !frame_end)
      |=> (control_byte == $past(rx_byte)) && (st.state == QDC_ST_HIGH))
    else $error("control byte not captured");

  upper_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (fire && !powerdown_flag && mode == `QDC_MODE_SINGLE && pick == 2'h0)
      |=> output_code_ch_a == {2'h0, $past(st.upper), $past(st.lower[7:6])})
    else $error("data word packing wrong");

  hold_no_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    !fire |=> $stable(output_code_ch_a) && $stable(output_code_ch_b)
      && $stable(output_code_ch_c) && $stable(output_code_ch_d))
    else $error("output changed without acknowledge edge");

  temp_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (fire && mode == `QDC_MODE_TEMP && pick == 2'h2)
      |=> (temp_hold_ch_c == $past(new_word)) && $stable(output_code_ch_c))
    else $error("temp-only write moved output");

  single_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (fire && mode == `QDC_MODE_SINGLE && pick == 2'h3)
      |=> (output_code_ch_d == $past(new_word)) && $stable(output_code_ch_a))
    else $error("single load wrong");

  all_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    (fire && mode == `QDC_MODE_ALL && pick == 2'h1)
      |=> (output_code_ch_a == $past(temp_hold_ch_a)) && (output_code_ch_b == $past(new_word)))
    else $error("all-channel load wrong");

  bcast_temp_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    (fire && mode == `QDC_MODE_BCAST && !channel_pick_hi)
      |=> (output_code_ch_c == $past(temp_hold_ch_c)) && $stable(temp_hold_ch_c))
    else $error("broadcast from temps wrong");

  bcast_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    (fire && mode == `QDC_MODE_BCAST && channel_pick_hi)
      |=> (output_code_ch_a == $past(new_word)) && (output_code_ch_d == $past(new_word)))
    else $error("broadcast data load wrong");

  pd_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    (fire && powerdown_flag && mode == `QDC_MODE_BCAST && channel_pick_hi)
      |=> output_code_ch_b == {$past(st.upper[7:6]), 10'h000})
    else $error("power-down code wrong");

  pd_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
    (fire && powerdown_flag && !frame_begin && !frame_end) |=> st.state == QDC_ST_DONE)
    else $error("power-down pair not terminal");

  pair_repeat_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
    (fire && !powerdown_flag && !frame_begin && !frame_end) |=> st.state == QDC_ST_HIGH ##0 update_done)
    else $error("data pair did not rearm");

  reset_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    $rose(rst_n) |-> (output_code_ch_a == 12'h000) && (temp_hold_ch_d == 12'h000))
    else $error("registers not cleared at reset");

  pick_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    (fire && mode == `QDC_MODE_TEMP && pick == 2'h1)
      |=> (temp_hold_ch_b == $past(new_word)) && $stable(temp_hold_ch_a) && $stable(temp_hold_ch_d))
    else $error("channel select wrong");

  temp_pd_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    (fire && mode == `QDC_MODE_TEMP && powerdown_flag && pick == 2'h0)
      |=> (temp_hold_ch_a == {$past(st.upper[7:6]), 10'h000}) && $stable(output_code_ch_a))
    else $error("temp power-down write wrong");

  all_pd_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    (fire && mode == `QDC_MODE_ALL && powerdown_flag && pick == 2'h3)
      |=> (output_code_ch_d == $past(new_word)) && (output_code_ch_c == $past(temp_hold_ch_c)))
    else $error("all-channel power-down load wrong");

  low_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (fire && !powerdown_flag && mode == `QDC_MODE_TEMP && pick == 2'h3)
      |=> temp_hold_ch_d[1:0] == $past(st.lower[7:6]))
    else $error("low conversion bits wrong");

  temp_layout_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    (fire && powerdown_flag && mode == `QDC_MODE_SINGLE && pick == 2'h1)
      |=> (temp_hold_ch_b[9:0] == 10'h000) && (temp_hold_ch_b[11:10] == $past(st.upper[7:6])))
    else $error("temp hold layout wrong");

  code_layout_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
    (fire && !powerdown_flag && mode == `QDC_MODE_SINGLE && pick == 2'h0)
      |=> (output_code_ch_a[11:10] == 2'h0) && (output_code_ch_a[9:2] == $past(st.upper)))
    else $error("output code layout wrong");

  bcast_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    (fire && mode == `QDC_MODE_BCAST && channel_pick_hi)
      |=> $stable(temp_hold_ch_a) && $stable(temp_hold_ch_b))
    else $error("broadcast data touched temp hold");

  done_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    update_done
      |=> !update_done)
    else $error("update pulse too long");

endmodule // qdc_control

// file: qdc_map.svh
// Field positions, mode encodings and reset values for the quad DAC control logic
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH

// Control byte fields
`define QDC_CTL_MODE_HI 5
`define QDC_CTL_MODE_LO 4
`define QDC_CTL_PICK_HI 2
`define QDC_CTL_PICK_LO 1
`define QDC_CTL_PD_FLAG 0

// Upper data byte power-down code bits
`define QDC_PD_CODE_HI 7
`define QDC_PD_CODE_LO 6

// Lower data byte conversion bits
`define QDC_LOW_BITS_HI 7
`define QDC_LOW_BITS_LO 6

// Update mode encodings
`define QDC_MODE_TEMP 2'h0
`define QDC_MODE_SINGLE 2'h1
`define QDC_MODE_ALL 2'h2
`define QDC_MODE_BCAST 2'h3

// Reset values
`define QDC_CTL_RESET 8'h00
`define QDC_BYTE_RESET 8'h00
`define QDC_WORD_RESET 12'h000
`define QDC_DATA_ZERO 10'h000

`endif

// file: qdc_pkg.sv
// Types shared by the quad DAC control logic
package qdc_pkg;

  typedef enum logic [2:0] {
    QDC_ST_IDLE = 3'h0,
    QDC_ST_CTRL = 3'h1,
    QDC_ST_HIGH = 3'h2,
    QDC_ST_LOW = 3'h3,
    QDC_ST_PEND = 3'h4,
    QDC_ST_DONE = 3'h5
  } qdc_state_t;

  typedef struct packed {
    qdc_state_t state;
    logic [7:0] control;
    logic [7:0] upper;
    logic [7:0] lower;
    logic updated;
  } qdc_core_t;

  typedef struct packed {
    logic [11:0] temp;
    logic [11:0] code;
  } qdc_chan_t;

endpackage

// file: qdc_channel.sv
// One channel: temporary hold register and output code register
`include "qdc_map.svh"

module qdc_channel
  import qdc_pkg::*;
#(
  parameter int WORD_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_temp,
  input wire logic ld_out,
  input wire logic ld_new,
  input wire logic [WORD_W-1:0] new_word,
  output logic [WORD_W-1:0] temp,
  output logic [WORD_W-1:0] code
);

  qdc_chan_t st;
  qdc_chan_t next_st;

  always_comb begin
    next_st = st;
    if (wr_temp) begin
      next_st.temp = new_word;
    end
    // Old temp is used so other channels load what was stored before
    if (ld_out) begin
      next_st.code = ld_new ? new_word : st.temp;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st.temp <= `QDC_WORD_RESET;
      st.code <= `QDC_WORD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign temp = st.temp;
  assign code = st.code;

endmodule // qdc_channel

// file: qdc_master_model.sv
// Bus master side model: byte engine events toward the control decoder
module qdc_master_model (
  input wire logic clk_sys,
  output logic frame_begin,
  output logic frame_end,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic ack_fall
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    frame_begin = 1'b0;
    frame_end = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h5a;
    ack_fall = 1'b0;
  end

  // Kind 0 start, 1 byte, 2 acknowledge edge, 3 stop; one cycle each
  task automatic strobe(input int kind, input logic [7:0] b);
    @(negedge clk_sys);
    frame_begin <= (kind == 0);
    rx_valid <= (kind == 1);
    ack_fall <= (kind == 2);
    frame_end <= (kind == 3);
    // Outside a byte strobe the bus toggles to the complement of its last value
    rx_byte <= (kind == 1) ? b : ~rx_byte;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      frame_begin <= 1'b0;
      rx_valid <= 1'b0;
      ack_fall <= 1'b0;
      frame_end <= 1'b0;
      rx_byte <= ~rx_byte;
    end
  endtask
endmodule // qdc_master_model

// file: qdc_control_bench.sv
// Self-checking bench for the quad DAC control decoder
module qdc_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys;
  logic rst_n;
  wire logic frame_begin, frame_end, rx_valid, ack_fall, update_done;
  wire logic [7:0] rx_byte, control_byte, upper_data_byte, lower_data_byte;
  wire logic [3:0][11:0] tq, cq;
  int mt [4];
  int mc [4];
  int mismatches;
  int checks;

  qdc_master_model u_mst (.clk_sys(clk_sys), .frame_begin(frame_begin), .frame_end(frame_end),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .ack_fall(ack_fall));

  qdc_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .frame_begin(frame_begin), .frame_end(frame_end),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .ack_fall(ack_fall), .control_byte(control_byte),
    .upper_data_byte(upper_data_byte), .lower_data_byte(lower_data_byte), .update_done(update_done),
    .temp_hold_ch_a(tq[0]), .temp_hold_ch_b(tq[1]), .temp_hold_ch_c(tq[2]), .temp_hold_ch_d(tq[3]),
    .output_code_ch_a(cq[0]), .output_code_ch_b(cq[1]), .output_code_ch_c(cq[2]), .output_code_ch_d(cq[3]));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_all;
    for (int i = 0; i < 4; i++) begin
      cmp_word(tq[i], 12'(mt[i]));
      cmp_word(cq[i], 12'(mc[i]));
    end
  endtask

  // Gap > 0 holds the acknowledge back to show nothing moves early
  task automatic do_pair(input logic [7:0] ctl, input logic [7:0] up, input logic [7:0] lo, input int gap);
    int p;
    int w;
    int n;
    p = int'(ctl[2:1]);
    w = ctl[0] ? int'({up[7:6], 10'h000}) : int'({up, lo[7:6]});
    u_mst.strobe(1, up);
    u_mst.strobe(1, lo);
    if (gap > 0) begin
      u_mst.idle(gap);
      cmp_all();
    end
    u_mst.strobe(2, 8'h00);
    u_mst.idle(1);
    for (n = 0; n < 6 && update_done !== 1'b1; n++) begin
      @(negedge clk_sys);
    end
    if (n == 6) begin
      mismatches++;
      wrap_up();
    end
    if (ctl[5:4] != 2'h3) mt[p] = w;
    if (ctl[5:4] == 2'h1) mc[p] = w;
    for (int i = 0; i < 4; i++) begin
      if (ctl[5:4] == 2'h2 || (ctl[5:4] == 2'h3 && !ctl[2])) mc[i] = mt[i];
      if (ctl[5:4] == 2'h3 && ctl[2]) mc[i] = w;
    end
    cmp_all();
    cmp_byte(upper_data_byte, up);
    cmp_byte(lower_data_byte, lo);
    // Done flag must drop after a single cycle
    @(negedge clk_sys);
    cmp_byte({7'h00, update_done}, 8'h00);
  endtask

  task automatic frame(input logic [7:0] ctl, input int pairs, input int gap);
    logic [7:0] r;
    u_mst.strobe(0, 8'h00);
    u_mst.strobe(1, ctl);
    u_mst.idle(1);
    cmp_byte(control_byte, ctl);
    for (int k = 0; k < (ctl[0] ? 1 : pairs); k++) begin
      r = 8'($urandom);
      if (ctl[0]) do_pair(ctl, {r[7:6], 6'h00}, 8'h00, gap);
      else do_pair(ctl, r, 8'($urandom), gap);
    end
    u_mst.strobe(3, 8'h00);
    u_mst.idle(1);
  endtask

  initial begin
    rst_n = 1'b0;
    mismatches = 0;
    checks = 0;
    void'($urandom(34578));
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    cmp_all();
    cmp_byte(control_byte, 8'h00);
    // Every mode, channel and flag outside broadcast; bit 3 random
    for (int m = 0; m < 24; m++) begin
      frame({2'h0, 2'(m / 8), 1'($urandom), 2'(m % 4), 1'((m / 4) % 2)}, 1 + m % 3, m % 2);
    end
    // Broadcast: top bits, bit 3 and bit 1 random as they are ignored
    for (int m = 0; m < 6; m++) begin
      frame({2'($urandom), 2'h3, 1'($urandom), 1'(m > 1), 1'($urandom),
        (m > 1) ? 1'(m > 3) : 1'($urandom)}, 2, m % 2);
    end
    // Mid-run reset once every register holds written data
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      mt[i] = 0;
      mc[i] = 0;
    end
    cmp_all();
    cmp_byte(control_byte, 8'h00);
    frame(8'h12, 1, 0);
    wrap_up();
  end
endmodule // qdc_control_bench
